// ### verilog/grm_top.sv
// Gyroscope register bank with byte-wide register port
// Operation
// - Offset 0x00 reads a fixed identification byte, read-only.
// - X, Y, Z rates at 0x02..0x07, low byte even, high byte odd.
// - Each axis is a signed 16-bit two's complement value over two bytes.
// - Reading a low byte freezes its high byte until that is read.
// - Rate scaling follows range register; reset code 0x00 means 2000 dps.
// - Self-test register 0x3C: trigger bit plus ready, fail, rate-ok flags.
// - Writing 0xB6 to soft reset restores config after 30 ms, any mode.
// - Sample-ready status clears itself 280 to 400 us after being set.
// - Overflow flag bit 7 stays until second buffer setup write.
// - Buffer status bits 6..0 show fill level, zero when empty.
`timescale 1ns/1ps
module grm_top #(
  parameter logic [7:0] ID_CODE = 8'h5a, // Arbitrary identification value
  parameter int READY_CLEAR_CYC = grm_pkg::READY_CLEAR_CYC,
  parameter int SOFT_RESET_CYC = grm_pkg::SOFT_RESET_CYC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Register port
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic [6:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  // Sampling core
  input wire logic I_SAMPLE_VALID,
  input wire logic [15:0] I_RATE_X,
  input wire logic [15:0] I_RATE_Y,
  input wire logic [15:0] I_RATE_Z,
  // Built-in test engine
  input wire logic I_BIST_DONE,
  input wire logic I_BIST_FAIL,
  input wire logic I_RATE_OK,
  output logic O_BIST_START,
  // Buffer engine
  input wire logic I_BUF_OVERRUN,
  input wire logic I_BUF_EVENT,
  input wire logic [6:0] I_BUF_LEVEL,
  input wire logic [7:0] I_BUF_DATA,
  output logic O_BUF_POP,
  output logic O_BUF_RESTART,
  // Configuration toward the core
  output logic [7:0] O_FULL_SCALE,
  output logic [7:0] O_FILTER_RATE,
  output logic [7:0] O_POWER_STATE,
  output logic [7:0] O_EVENT_ENABLE,
  output logic [7:0] O_PIN_ELECTRICAL,
  output logic [7:0] O_PIN_ROUTING,
  output logic [7:0] O_LEVEL_EVENT_EN,
  output logic [7:0] O_EXT_SYNC,
  output logic [7:0] O_SETUP_FIRST,
  output logic [7:0] O_SETUP_SECOND,
  output logic O_RESET_PENDING
);
  generate
    if (READY_CLEAR_CYC < 1 || SOFT_RESET_CYC < 1) begin : g_bad
      $error("grm_top timing counts must be at least one");
    end
  endgenerate

  logic rd_hit;
  logic wr_hit;
  assign rd_hit = I_RD && !I_WR;
  assign wr_hit = I_WR && !I_RD;

  function automatic logic rd_at(input logic [6:0] a, input logic [6:0] o);
    rd_at = (a == o);
  endfunction

  // Axis holders
  logic [7:0] x_low, x_high, y_low, y_high, z_low, z_high;
  logic x_lock, y_lock, z_lock;

  grm_axis_hold u_x (
    .i_clk(I_CLK), .i_arst_n(I_ARST_N),
    .i_sample_valid(I_SAMPLE_VALID), .i_sample(I_RATE_X),
    .i_rd_low(rd_hit && rd_at(I_ADDR, grm_pkg::OFS_X_LOW)),
    .i_rd_high(rd_hit && rd_at(I_ADDR, grm_pkg::OFS_X_HIGH)),
    .o_low(x_low), .o_high(x_high), .o_locked(x_lock)
  );
  grm_axis_hold u_y (
    .i_clk(I_CLK), .i_arst_n(I_ARST_N),
    .i_sample_valid(I_SAMPLE_VALID), .i_sample(I_RATE_Y),
    .i_rd_low(rd_hit && rd_at(I_ADDR, grm_pkg::OFS_Y_LOW)),
    .i_rd_high(rd_hit && rd_at(I_ADDR, grm_pkg::OFS_Y_HIGH)),
    .o_low(y_low), .o_high(y_high), .o_locked(y_lock)
  );
  grm_axis_hold u_z (
    .i_clk(I_CLK), .i_arst_n(I_ARST_N),
    .i_sample_valid(I_SAMPLE_VALID), .i_sample(I_RATE_Z),
    .i_rd_low(rd_hit && rd_at(I_ADDR, grm_pkg::OFS_Z_LOW)),
    .i_rd_high(rd_hit && rd_at(I_ADDR, grm_pkg::OFS_Z_HIGH)),
    .o_low(z_low), .o_high(z_high), .o_locked(z_lock)
  );

  // Timers
  logic swrst_cmd;
  logic swrst_done;
  logic ready_done;
  assign swrst_cmd = wr_hit && (I_ADDR == grm_pkg::OFS_SOFT_RESET)
    && (I_WDATA == grm_pkg::SOFT_RESET_CODE);

  grm_timer #(.CYCLES(SOFT_RESET_CYC)) u_swrst (
    .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_start(swrst_cmd),
    .o_busy(O_RESET_PENDING), .o_done(swrst_done)
  );
  grm_timer #(.CYCLES(READY_CLEAR_CYC)) u_ready (
    .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_start(I_SAMPLE_VALID),
    .o_busy(), .o_done(ready_done)
  );

  // Configuration group
  logic [7:0] full_scale, filter_rate, power_state, event_enable;
  logic [7:0] pin_electrical, pin_routing, level_event_en, ext_sync;
  logic [7:0] setup_first, setup_second;
  logic [7:0] next_full_scale, next_filter_rate, next_power_state;
  logic [7:0] next_event_enable, next_pin_electrical, next_pin_routing;
  logic [7:0] next_level_event_en, next_ext_sync;
  logic [7:0] next_setup_first, next_setup_second;

  always_comb begin
    next_full_scale = full_scale;
    next_filter_rate = filter_rate;
    next_power_state = power_state;
    next_event_enable = event_enable;
    next_pin_electrical = pin_electrical;
    next_pin_routing = pin_routing;
    next_level_event_en = level_event_en;
    next_ext_sync = ext_sync;
    next_setup_first = setup_first;
    next_setup_second = setup_second;
    if (swrst_done) begin
      // Delayed restore wins over a write in the same cycle
      next_full_scale = grm_pkg::RST_FULL_SCALE;
      next_filter_rate = grm_pkg::RST_FILTER_RATE;
      next_power_state = grm_pkg::RST_POWER_STATE;
      next_event_enable = grm_pkg::RST_EVENT_ENABLE;
      next_pin_electrical = grm_pkg::RST_PIN_ELECTRICAL;
      next_pin_routing = grm_pkg::RST_PIN_ROUTING;
      next_level_event_en = grm_pkg::RST_LEVEL_EVENT_EN;
      next_ext_sync = grm_pkg::RST_EXT_SYNC;
      next_setup_first = grm_pkg::RST_SETUP_FIRST;
      next_setup_second = grm_pkg::RST_SETUP_SECOND;
    end else if (wr_hit) begin
      unique case (I_ADDR)
        grm_pkg::OFS_FULL_SCALE: next_full_scale = I_WDATA;
        grm_pkg::OFS_FILTER_RATE: begin
          next_filter_rate = I_WDATA;
          next_filter_rate[grm_pkg::BIT_FILTER_FIXED] = 1'b1;
        end
        grm_pkg::OFS_POWER_STATE: next_power_state = I_WDATA;
        grm_pkg::OFS_EVENT_ENABLE: next_event_enable = I_WDATA;
        grm_pkg::OFS_PIN_ELECTRICAL: next_pin_electrical = I_WDATA;
        grm_pkg::OFS_PIN_ROUTING: next_pin_routing = I_WDATA;
        grm_pkg::OFS_LEVEL_EVENT_EN: next_level_event_en = I_WDATA;
        grm_pkg::OFS_EXT_SYNC: next_ext_sync = I_WDATA;
        grm_pkg::OFS_SETUP_FIRST: next_setup_first = I_WDATA;
        grm_pkg::OFS_SETUP_SECOND: next_setup_second = I_WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      full_scale <= grm_pkg::RST_FULL_SCALE;
      filter_rate <= grm_pkg::RST_FILTER_RATE;
      power_state <= grm_pkg::RST_POWER_STATE;
      event_enable <= grm_pkg::RST_EVENT_ENABLE;
      pin_electrical <= grm_pkg::RST_PIN_ELECTRICAL;
      pin_routing <= grm_pkg::RST_PIN_ROUTING;
      level_event_en <= grm_pkg::RST_LEVEL_EVENT_EN;
      ext_sync <= grm_pkg::RST_EXT_SYNC;
      setup_first <= grm_pkg::RST_SETUP_FIRST;
      setup_second <= grm_pkg::RST_SETUP_SECOND;
    end else begin
      full_scale <= next_full_scale;
      filter_rate <= next_filter_rate;
      power_state <= next_power_state;
      event_enable <= next_event_enable;
      pin_electrical <= next_pin_electrical;
      pin_routing <= next_pin_routing;
      level_event_en <= next_level_event_en;
      ext_sync <= next_ext_sync;
      setup_first <= next_setup_first;
      setup_second <= next_setup_second;
    end
  end

  // Status group
  logic sample_ready, overflow, test_ready, test_fail, rate_ok;
  logic next_sample_ready, next_overflow, next_test_ready;
  logic next_test_fail, next_rate_ok;
  logic test_cmd;
  logic setup2_wr;
  assign test_cmd = wr_hit && (I_ADDR == grm_pkg::OFS_BUILTIN_TEST)
    && I_WDATA[grm_pkg::BIT_TEST_TRIGGER];
  assign setup2_wr = wr_hit && (I_ADDR == grm_pkg::OFS_SETUP_SECOND);

  always_comb begin
    next_sample_ready = sample_ready;
    next_overflow = overflow;
    next_test_ready = test_ready;
    next_test_fail = test_fail;
    next_rate_ok = rate_ok;
    if (I_SAMPLE_VALID) begin
      next_sample_ready = 1'b1;
    end else if (ready_done) begin
      next_sample_ready = 1'b0;
    end
    // A new overrun in the clearing cycle is kept
    if (I_BUF_OVERRUN) begin
      next_overflow = 1'b1;
    end else if (setup2_wr) begin
      next_overflow = 1'b0;
    end
    if (I_BIST_DONE) begin
      next_test_ready = 1'b1;
      next_test_fail = I_BIST_FAIL;
      next_rate_ok = I_RATE_OK;
    end else if (test_cmd) begin
      next_test_ready = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sample_ready <= 1'b0;
      overflow <= 1'b0;
      test_ready <= 1'b0;
      test_fail <= 1'b0;
      rate_ok <= 1'b0;
    end else begin
      sample_ready <= next_sample_ready;
      overflow <= next_overflow;
      test_ready <= next_test_ready;
      test_fail <= next_test_fail;
      rate_ok <= next_rate_ok;
    end
  end

  // Read mux, answered one cycle after the strobe
  logic [7:0] rd_mux;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] next_rdata;
  logic next_rvalid;

  always_comb begin
    rd_mux = 8'h00;
    unique case (I_ADDR)
      grm_pkg::OFS_IDENTITY: rd_mux = ID_CODE;
      grm_pkg::OFS_X_LOW: rd_mux = x_low;
      grm_pkg::OFS_X_HIGH: rd_mux = x_high;
      grm_pkg::OFS_Y_LOW: rd_mux = y_low;
      grm_pkg::OFS_Y_HIGH: rd_mux = y_high;
      grm_pkg::OFS_Z_LOW: rd_mux = z_low;
      grm_pkg::OFS_Z_HIGH: rd_mux = z_high;
      grm_pkg::OFS_EVENT_STATUS: begin
        rd_mux[grm_pkg::BIT_SAMPLE_READY] = sample_ready;
        rd_mux[grm_pkg::BIT_BUFFER_EVENT] = I_BUF_EVENT;
      end
      grm_pkg::OFS_BUFFER_STATUS: rd_mux = {overflow, I_BUF_LEVEL};
      grm_pkg::OFS_FULL_SCALE: rd_mux = full_scale;
      grm_pkg::OFS_FILTER_RATE: rd_mux = filter_rate;
      grm_pkg::OFS_POWER_STATE: rd_mux = power_state;
      grm_pkg::OFS_EVENT_ENABLE: rd_mux = event_enable;
      grm_pkg::OFS_PIN_ELECTRICAL: rd_mux = pin_electrical;
      grm_pkg::OFS_PIN_ROUTING: rd_mux = pin_routing;
      grm_pkg::OFS_LEVEL_EVENT_EN: rd_mux = level_event_en;
      grm_pkg::OFS_EXT_SYNC: rd_mux = ext_sync;
      grm_pkg::OFS_BUILTIN_TEST: begin
        rd_mux[grm_pkg::BIT_TEST_READY] = test_ready;
        rd_mux[grm_pkg::BIT_TEST_FAIL] = test_fail;
        rd_mux[grm_pkg::BIT_RATE_OK] = rate_ok;
      end
      grm_pkg::OFS_SETUP_FIRST: rd_mux = setup_first;
      grm_pkg::OFS_SETUP_SECOND: rd_mux = setup_second;
      grm_pkg::OFS_READ_PORT: rd_mux = I_BUF_DATA;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_rdata = rdata;
    next_rvalid = rd_hit;
    if (rd_hit) begin
      next_rdata = rd_mux;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign O_RDATA = rdata;
  assign O_RVALID = rvalid;
  assign O_BIST_START = test_cmd;
  assign O_BUF_POP = rd_hit && (I_ADDR == grm_pkg::OFS_READ_PORT);
  assign O_BUF_RESTART = setup2_wr;
  assign O_FULL_SCALE = full_scale;
  assign O_FILTER_RATE = filter_rate;
  assign O_POWER_STATE = power_state;
  assign O_EVENT_ENABLE = event_enable;
  assign O_PIN_ELECTRICAL = pin_electrical;
  assign O_PIN_ROUTING = pin_routing;
  assign O_LEVEL_EVENT_EN = level_event_en;
  assign O_EXT_SYNC = ext_sync;
  assign O_SETUP_FIRST = setup_first;
  assign O_SETUP_SECOND = setup_second;

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  logic [31:0] ready_age;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ready_age <= 32'h0000_0000;
    end else if (I_SAMPLE_VALID) begin
      ready_age <= 32'h0000_0000;
    end else if (sample_ready) begin
      ready_age <= ready_age + 32'h0000_0001;
    end
  end

  a_id_fixed: assert property (rd_hit && I_ADDR == grm_pkg::OFS_IDENTITY
    |=> O_RVALID && O_RDATA == ID_CODE)
    else $error("identity read returned a wrong byte");
  a_axis_bytes: assert property (rd_hit && I_ADDR == grm_pkg::OFS_X_HIGH
    |=> O_RDATA == $past(x_high))
    else $error("x high byte read mismatch");
  a_reserved_zero: assert property (rd_hit && I_ADDR == 7'h01
    |=> O_RDATA == 8'h00)
    else $error("reserved offset read nonzero");
  a_ready_life: assert property ($fell(sample_ready)
    |-> $past(ready_age) == 32'(READY_CLEAR_CYC - 1))
    else $error("sample ready cleared at the wrong time");
  a_ovr_sticky: assert property (overflow && !setup2_wr |=> overflow)
    else $error("overflow flag dropped without a setup write");
  a_ovr_clear: assert property (setup2_wr && !I_BUF_OVERRUN
    |=> !overflow)
    else $error("overflow flag not cleared by setup write");
  a_level_read: assert property (rd_hit
    && I_ADDR == grm_pkg::OFS_BUFFER_STATUS
    |=> O_RDATA[6:0] == $past(I_BUF_LEVEL))
    else $error("fill level read mismatch");
  a_swrst_restore: assert property (swrst_done
    |=> O_FULL_SCALE == 8'h00 && O_FILTER_RATE == 8'h80
    && O_PIN_ELECTRICAL == 8'h0f)
    else $error("soft reset did not restore configuration");
  a_range_write: assert property (wr_hit && !swrst_done
    && I_ADDR == grm_pkg::OFS_FULL_SCALE
    |=> O_FULL_SCALE == $past(I_WDATA))
    else $error("range write not taken");
  a_test_ready: assert property (I_BIST_DONE
    |=> test_ready && test_fail == $past(I_BIST_FAIL))
    else $error("self-test outcome not captured");

  c_ready_expiry: cover property ($fell(sample_ready));
  c_ovr_cleared: cover property (overflow ##1 setup2_wr ##1 !overflow);
  c_swrst: cover property (swrst_done);
  c_locked_pair: cover property (x_lock ##[1:20] !x_lock);
endmodule // grm_top

// ### verilog/grm_pkg.sv
// Constants shared by the gyroscope register bank
package grm_pkg;
  // Byte offsets of the register map
  localparam logic [6:0] OFS_IDENTITY = 7'h00;
  localparam logic [6:0] OFS_X_LOW = 7'h02;
  localparam logic [6:0] OFS_X_HIGH = 7'h03;
  localparam logic [6:0] OFS_Y_LOW = 7'h04;
  localparam logic [6:0] OFS_Y_HIGH = 7'h05;
  localparam logic [6:0] OFS_Z_LOW = 7'h06;
  localparam logic [6:0] OFS_Z_HIGH = 7'h07;
  localparam logic [6:0] OFS_EVENT_STATUS = 7'h0a;
  localparam logic [6:0] OFS_BUFFER_STATUS = 7'h0e;
  localparam logic [6:0] OFS_FULL_SCALE = 7'h0f;
  localparam logic [6:0] OFS_FILTER_RATE = 7'h10;
  localparam logic [6:0] OFS_POWER_STATE = 7'h11;
  localparam logic [6:0] OFS_SOFT_RESET = 7'h14;
  localparam logic [6:0] OFS_EVENT_ENABLE = 7'h15;
  localparam logic [6:0] OFS_PIN_ELECTRICAL = 7'h16;
  localparam logic [6:0] OFS_PIN_ROUTING = 7'h18;
  localparam logic [6:0] OFS_LEVEL_EVENT_EN = 7'h1e;
  localparam logic [6:0] OFS_EXT_SYNC = 7'h34;
  localparam logic [6:0] OFS_BUILTIN_TEST = 7'h3c;
  localparam logic [6:0] OFS_SETUP_FIRST = 7'h3d;
  localparam logic [6:0] OFS_SETUP_SECOND = 7'h3e;
  localparam logic [6:0] OFS_READ_PORT = 7'h3f;
  // Values after reset
  localparam logic [7:0] RST_FULL_SCALE = 8'h00;
  localparam logic [7:0] RST_FILTER_RATE = 8'h80;
  localparam logic [7:0] RST_POWER_STATE = 8'h00;
  localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
  localparam logic [7:0] RST_PIN_ELECTRICAL = 8'h0f;
  localparam logic [7:0] RST_PIN_ROUTING = 8'h00;
  localparam logic [7:0] RST_LEVEL_EVENT_EN = 8'h00;
  localparam logic [7:0] RST_EXT_SYNC = 8'h00;
  localparam logic [7:0] RST_SETUP_FIRST = 8'h00;
  localparam logic [7:0] RST_SETUP_SECOND = 8'h00;
  // Field positions
  localparam int BIT_FILTER_FIXED = 7;
  localparam int BIT_SAMPLE_READY = 7;
  localparam int BIT_BUFFER_EVENT = 4;
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_TEST_TRIGGER = 0;
  localparam int BIT_TEST_READY = 1;
  localparam int BIT_TEST_FAIL = 2;
  localparam int BIT_RATE_OK = 4;
  // Command code and timing
  localparam logic [7:0] SOFT_RESET_CODE = 8'hb6;
  localparam int CLK_MHZ = 200;
  localparam int READY_CLEAR_US = 300;
  localparam int SOFT_RESET_MS = 30;
  localparam int READY_CLEAR_CYC = READY_CLEAR_US * CLK_MHZ;
  localparam int SOFT_RESET_CYC = SOFT_RESET_MS * 1000 * CLK_MHZ;
endpackage

// ### verilog/grm_timer.sv
// One-shot countdown timer with a done pulse
`timescale 1ns/1ps
module grm_timer #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_start,
  // Status
  output logic o_busy,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  generate
    if (CYCLES < 1) begin : g_bad
      $error("grm_timer needs at least one cycle");
    end
  endgenerate

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (i_start) begin
      next_cnt = LOAD;
    end else if (cnt != '0) begin
      next_cnt = cnt - ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // A restart in the last cycle suppresses the pulse
  assign o_done = (cnt == ONE) && !i_start;
  assign o_busy = (cnt != '0);
endmodule // grm_timer

// ### verilog/grm_axis_hold.sv
// One axis sample with high-byte freeze after a low-byte read
`timescale 1ns/1ps
module grm_axis_hold (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Sample from the sampling core
  input wire logic i_sample_valid,
  input wire logic signed [15:0] i_sample,
  // Read strobes
  input wire logic i_rd_low,
  input wire logic i_rd_high,
  // Held value
  output logic [7:0] o_low,
  output logic [7:0] o_high,
  output logic o_locked
);
  logic [15:0] value;
  logic locked;
  logic [15:0] next_value;
  logic next_locked;

  always_comb begin
    next_value = value;
    next_locked = locked;
    // The whole word freezes so both halves share one sample
    if (i_sample_valid && !locked && !i_rd_low) begin
      next_value = i_sample;
    end
    if (i_rd_low) begin
      next_locked = 1'b1;
    end else if (i_rd_high) begin
      next_locked = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      value <= 16'h0000;
      locked <= 1'b0;
    end else begin
      value <= next_value;
      locked <= next_locked;
    end
  end

  assign o_low = value[7:0];
  assign o_high = value[15:8];
  assign o_locked = locked;

  a_frozen_word: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    locked && !i_rd_high |=> $stable(value))
    else $error("held word changed while locked");
  a_low_locks: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd_low |=> locked ##0 $stable(value))
    else $error("low read did not freeze the word");
endmodule // grm_axis_hold

// ### tb/grm_host.sv
// Host model driving the byte-wide register port
`timescale 1ns/1ps
module grm_host (
  // Clock
  input wire logic i_clk,
  // Register port
  output logic o_rd,
  output logic o_wr,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 7'h7f;
    o_wdata = 8'h00;
  end

  // Strobe lasts exactly one cycle; address and data are scrambled after
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d,
      output bit ok);
    int n;
    ok = 1'b0;
    d = 8'hxx;
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clk);
      if (i_rvalid === 1'b1) begin
        d = i_rdata;
        ok = 1'b1;
      end
    end
  endtask

  // Low byte first so the high byte stays frozen until read
  task automatic rd_axis(input logic [6:0] a,
      output logic signed [15:0] v, output bit ok);
    logic [7:0] lo;
    logic [7:0] hi;
    bit k1;
    bit k2;
    rd(a, lo, k1);
    rd(a + 7'h01, hi, k2);
    v = $signed({8'h00, hi} * 16'h0100 + {8'h00, lo});
    ok = k1 && k2;
  endtask
endmodule // grm_host

// ### tb/gyro_register_map_bench.sv
// Self-checking bench for the gyroscope register bank
`timescale 1ns/1ps
module gyro_register_map_bench;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identification value
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rd, wr, rvalid, vld, b_done, b_fail, r_ok, ovr, b_evt, pend;
  logic b_start, pop, restart;
  logic [6:0] addr, lvl, lv;
  logic [7:0] wdata, rdata, bdata, d, w;
  wire [7:0] co [10];
  logic [15:0] rx, ry, rz, s0;
  logic signed [15:0] v;
  bit ok;
  int fail_count = 0;
  int check_count = 0;
  int starts = 0;
  int pops = 0;
  int restarts = 0;
  logic [6:0] cfg [10] = '{7'h0f, 7'h10, 7'h11, 7'h15, 7'h16, 7'h18,
    7'h1e, 7'h34, 7'h3d, 7'h3e};
  logic [7:0] crst [10] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h0f, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};

  always #2.5 clk = ~clk;
  // Pulses are counted mid-cycle, away from the edge that ends them
  always @(negedge clk) begin
    if (b_start === 1'b1) starts++;
    if (pop === 1'b1) pops++;
    if (restart === 1'b1) restarts++;
  end

  grm_host host_u (.i_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

  grm_top #(.ID_CODE(ID), .READY_CLEAR_CYC(20), .SOFT_RESET_CYC(50)) dut_u (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_RD(rd), .I_WR(wr), .I_ADDR(addr),
    .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
    .I_SAMPLE_VALID(vld), .I_RATE_X(rx), .I_RATE_Y(ry), .I_RATE_Z(rz),
    .I_BIST_DONE(b_done), .I_BIST_FAIL(b_fail), .I_RATE_OK(r_ok),
    .O_BIST_START(b_start), .I_BUF_OVERRUN(ovr), .I_BUF_EVENT(b_evt),
    .I_BUF_LEVEL(lvl), .I_BUF_DATA(bdata), .O_BUF_POP(pop),
    .O_BUF_RESTART(restart), .O_FULL_SCALE(co[0]), .O_FILTER_RATE(co[1]),
    .O_POWER_STATE(co[2]), .O_EVENT_ENABLE(co[3]),
    .O_PIN_ELECTRICAL(co[4]), .O_PIN_ROUTING(co[5]),
    .O_LEVEL_EVENT_EN(co[6]), .O_EXT_SYNC(co[7]), .O_SETUP_FIRST(co[8]),
    .O_SETUP_SECOND(co[9]), .O_RESET_PENDING(pend));

  // Bit 7 of the filter register is fixed high whatever is written
  function automatic logic [7:0] rback(input logic [6:0] a,
      input logic [7:0] x);
    return (a == 7'h10) ? (x | 8'h80) : x;
  endfunction

  function automatic logic [7:0] bist_exp(input logic f, input logic k);
    return {3'h0, k, 1'b0, f, 1'b1, 1'b0};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rreg(input logic [6:0] a, input logic [7:0] e,
      input string nm);
    host_u.rd(a, d, ok);
    // A missing answer leaves d unknown, so the compare fails as well
    if (!ok) fail_count++;
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask

  task automatic put(input int k, input logic [15:0] s);
    if (k == 0) rx <= s;
    else if (k == 1) ry <= s;
    else rz <= s;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    {vld, b_done, b_fail, r_ok, ovr, b_evt} = 6'h00;
    lvl = 7'h00;
    bdata = 8'h00;
    {rx, ry, rz} = 48'h0;
    void'($urandom(32'he9c468bb));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rreg(7'h00, ID, "ident");
    host_u.wr(7'h00, 8'h11);
    host_u.wr(7'h01, 8'hff);
    rreg(7'h00, ID, "ident_ro");
    rreg(7'h01, 8'h00, "rsvd01");
    rreg(7'h0c, 8'h00, "rsvd0c");
    $display("test ident done");
    for (int i = 0; i < 10; i++) begin
      rreg(cfg[i], crst[i], "cfg_rst");
      w = 8'($urandom());
      host_u.wr(cfg[i], w);
      rreg(cfg[i], rback(cfg[i], w), "cfg_rw");
      chk("cfg_out", {8'h00, rback(cfg[i], w)}, {8'h00, co[i]});
    end
    $display("test config done");
    b_evt <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      s0 = 16'($urandom());
      put(k, s0);
      fork
        host_u.rd_axis(7'(2 + 2 * k), v, ok);
        begin
          repeat (3) @(posedge clk);
          put(k, ~s0);
        end
      join
      chk("axis_word", s0, v);
      // The sample offered while locked is dropped, not deferred
      rreg(7'(3 + 2 * k), s0[15:8], "axis_hi_kept");
      put(k, ~s0);
      rreg(7'(3 + 2 * k), ~s0[15:8], "axis_hi_now");
    end
    rreg(7'h0a, 8'h90, "ready_set");
    repeat (25) @(posedge clk);
    rreg(7'h0a, 8'h10, "ready_gone");
    $display("test axis done");
    lv = 7'($urandom());
    lvl <= lv;
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
    rreg(7'h0e, {1'b1, lv}, "ovf_set");
    rreg(7'h0e, {1'b1, lv}, "ovf_kept");
    host_u.wr(7'h3e, 8'h00);
    rreg(7'h0e, {1'b0, lv}, "ovf_clr");
    chk("restarts", 16'h2, 16'(restarts));
    lvl <= 7'h00;
    rreg(7'h0e, 8'h00, "empty");
    w = 8'($urandom());
    bdata <= w;
    rreg(7'h3f, w, "read_port");
    chk("pops", 16'h1, 16'(pops));
    $display("test buffer done");
    for (int j = 0; j < 2; j++) begin
      host_u.wr(7'h3c, 8'h01);
      chk("bist_start", 16'(j + 1), 16'(starts));
      rreg(7'h3c, (j == 0) ? 8'h00 : 8'h10, "bist_clr");
      b_fail <= j[0];
      r_ok <= ~j[0];
      b_done <= 1'b1;
      @(posedge clk);
      b_done <= 1'b0;
      rreg(7'h3c, bist_exp(j[0], ~j[0]), "bist");
    end
    $display("test selftest done");
    host_u.wr(7'h0f, 8'h03);
    host_u.wr(7'h14, 8'h55);
    #1;
    chk("pend_other", 16'h0, {15'h0, pend});
    host_u.wr(7'h14, 8'hb6);
    #1;
    chk("pend_on", 16'h1, {15'h0, pend});
    chk("fs_held", 16'h3, {8'h00, co[0]});
    for (int n = 0; n < 80 && pend !== 1'b0; n++) @(posedge clk);
    chk("pend_off", 16'h0, {15'h0, pend});
    rreg(7'h0f, 8'h00, "fs_restored");
    rreg(7'h10, 8'h80, "bw_restored");
    $display("test softreset done");
    wrap_up();
  end
endmodule // gyro_register_map_bench
